// ### logic/mssp_pkg.sv
// Constants and types shared by the module serial select port design
package mssp_pkg;

    // ------------------------------------------------------------------
    // Slot-select word
    // ------------------------------------------------------------------
    localparam int SEL_W       = 16;
    localparam int SLOT_LSB    = 0;
    localparam int SLOT_W      = 4;
    localparam int CHASSIS_LSB = 8;
    localparam int CHASSIS_W   = 8;
    localparam logic [SEL_W-1:0] SEL_RESET = 16'h0000;
    localparam logic [CHASSIS_W-1:0] CHASSIS_ANY = 8'h00;

    // ------------------------------------------------------------------
    // Module registers
    // ------------------------------------------------------------------
    localparam int CFG_W = 16;
    localparam logic [CFG_W-1:0] CFG_RESET = 16'h0000;
    localparam int ID_W     = 32;
    localparam int ID_CNT_W = 6;
    // Identification value is arbitrary
    localparam logic [ID_W-1:0] ID_VALUE = 32'h0000_5a01;
    localparam logic [ID_CNT_W-1:0] ID_BITS = 6'h20;

    // ------------------------------------------------------------------
    // Channel multiplexer
    // ------------------------------------------------------------------
    localparam int MUX_W = 3;
    localparam logic [MUX_W-1:0] MUX_LAST  = 3'h4;
    localparam logic [MUX_W-1:0] MUX_RESET = 3'h0;

    typedef enum logic [1:0] {
        SEL_IDLE,
        SEL_ADDRESSING,
        SEL_ACTIVE
    } mssp_sel_state_t;

endpackage

// ### logic/mssp_link_if.sv
// Carrier between the select controller and the link-side module port
`timescale 1ns/1ps
interface mssp_link_if;
    import mssp_pkg::*;

    logic             link_rst_n;
    logic [CFG_W-1:0] cfg_stage;
    logic             cfg_written;
    logic             id_bit;

    modport ctrl (
        output link_rst_n,
        input  cfg_stage,
        input  cfg_written,
        input  id_bit
    );

    modport port (
        input  link_rst_n,
        output cfg_stage,
        output cfg_written,
        output id_bit
    );
endinterface

// ### logic/mssp_pin_sync.sv
// Two-stage pin synchroniser with edge pulses on bit zero
`timescale 1ns/1ps
module mssp_pin_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         nrst,
    // Pin side
    input  wire logic [W-1:0] pin,
    // Synchronised side
    output logic      [W-1:0] level,
    output logic              rise,
    output logic              fall
);
    logic [W-1:0] meta;
    logic         prev;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meta  <= '0;
            level <= '0;
            prev  <= 1'b0;
        end else begin
            meta  <= pin;
            level <= meta;
            prev  <= level[0];
        end
    end

    assign rise = level[0] & ~prev;
    assign fall = ~level[0] & prev;
endmodule

// ### logic/mssp_id_port.sv
// Link-side configuration capture and identification readout
`timescale 1ns/1ps
module mssp_id_port
    import mssp_pkg::*;
(
    // Link clock and lines
    input  wire logic serial_shift_clock,
    input  wire logic slot_zero_select_n,
    input  wire logic data_address_flag,
    input  wire logic serial_input_line,
    // Controller side
    mssp_link_if.port lif
);
    logic [ID_W-1:0]     id_shift;
    logic [ID_CNT_W-1:0] id_count;

    // ------------------------------------------------------------------
    // Configuration capture, held clear while the module is unselected
    // ------------------------------------------------------------------
    always_ff @(posedge serial_shift_clock or negedge lif.link_rst_n) begin
        if (!lif.link_rst_n) begin
            lif.cfg_stage   <= CFG_RESET;
            lif.cfg_written <= 1'b0;
        end else if (slot_zero_select_n && !data_address_flag) begin
            lif.cfg_stage   <= {lif.cfg_stage[CFG_W-2:0], serial_input_line};
            lif.cfg_written <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Identification readout, reloaded whenever select drops
    // ------------------------------------------------------------------
    always_ff @(negedge serial_shift_clock or negedge lif.link_rst_n) begin
        if (!lif.link_rst_n) begin
            id_shift   <= ID_VALUE;
            id_count   <= '0;
            lif.id_bit <= 1'b0;
        end else if (slot_zero_select_n) begin
            if (id_count < ID_BITS) begin
                lif.id_bit <= id_shift[ID_W-1];
                id_shift   <= {id_shift[ID_W-2:0], 1'b0};
                id_count   <= id_count + 6'h01;
            end else begin
                lif.id_bit <= 1'b0;
            end
        end
    end
endmodule

// ### logic/mssp_top.sv
// Module serial select port: slot selection, configuration, identification, scan
`timescale 1ns/1ps
module mssp_top
    import mssp_pkg::*;
(
    // System clock and reset
    input  wire logic                 clk,
    input  wire logic                 nrst,
    // Serial link from the acquisition board
    input  wire logic                 serial_shift_clock,
    input  wire logic                 serial_input_line,
    input  wire logic                 data_address_flag,
    input  wire logic                 slot_zero_select_n,
    output logic                      serial_output_line,
    // Scan timing
    input  wire logic                 scan_advance_clock,
    output logic                      backplane_trigger_line,
    output logic [MUX_W-1:0]          channel_mux_counter,
    // Straps giving this module's place in the system
    input  wire logic [SLOT_W-1:0]    slot_position,
    input  wire logic [CHASSIS_W-1:0] chassis_address,
    input  wire logic                 single_chassis_mode,
    // Module state
    output logic                      module_select,
    output logic [CFG_W-1:0]          config_word,
    output logic [SEL_W-1:0]          slot_select_word
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    mssp_link_if lif ();

    mssp_sel_state_t state;
    mssp_sel_state_t next_state;

    logic [SEL_W-1:0]     sel_shift;
    logic                 slot0_level;
    logic                 slot0_rise;
    logic                 slot0_fall;
    logic                 scan_level;
    logic                 scan_rise;
    logic [SLOT_W-1:0]    strap_slot;
    logic [CHASSIS_W-1:0] strap_chassis;
    logic                 strap_single;
    logic                 addressed;

    // ------------------------------------------------------------------
    // Address match
    // ------------------------------------------------------------------
    function automatic logic sel_match(
        input logic [SEL_W-1:0]     word,
        input logic [SLOT_W-1:0]    slot,
        input logic [CHASSIS_W-1:0] chassis,
        input logic                 single
    );
        logic slot_ok;
        logic chassis_ok;
        slot_ok    = (word[SLOT_LSB +: SLOT_W] == slot);
        chassis_ok = single || (chassis == CHASSIS_ANY)
                  || (word[CHASSIS_LSB +: CHASSIS_W] == chassis);
        return slot_ok && chassis_ok;
    endfunction

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    mssp_pin_sync #(
        .W (1)
    ) u_slot0_sync (
        .clk   (clk),
        .nrst  (nrst),
        .pin   (slot_zero_select_n),
        .level (slot0_level),
        .rise  (slot0_rise),
        .fall  (slot0_fall)
    );

    mssp_pin_sync #(
        .W (1)
    ) u_scan_sync (
        .clk   (clk),
        .nrst  (nrst),
        .pin   (scan_advance_clock),
        .level (scan_level),
        .rise  (scan_rise),
        .fall  ()
    );

    mssp_pin_sync #(
        .W (SLOT_W + CHASSIS_W + 1)
    ) u_strap_sync (
        .clk   (clk),
        .nrst  (nrst),
        .pin   ({single_chassis_mode, chassis_address, slot_position}),
        .level ({strap_single, strap_chassis, strap_slot}),
        .rise  (),
        .fall  ()
    );

    // ------------------------------------------------------------------
    // Slot-select shifter on the link clock
    // ------------------------------------------------------------------
    // Shifts only while slot-zero select is low, so the word is frozen
    // whenever the system side samples it after the rising edge.
    always_ff @(posedge serial_shift_clock or negedge nrst) begin
        if (!nrst) begin
            sel_shift <= SEL_RESET;
        end else if (!slot_zero_select_n) begin
            sel_shift <= {sel_shift[SEL_W-2:0], serial_input_line};
        end
    end

    // ------------------------------------------------------------------
    // Selection sequence
    // ------------------------------------------------------------------
    assign addressed = sel_match(sel_shift, strap_slot, strap_chassis, strap_single);

    always_comb begin
        next_state = state;
        unique case (state)
            SEL_IDLE: begin
                if (slot0_fall) begin
                    next_state = SEL_ADDRESSING;
                end
            end
            SEL_ADDRESSING: begin
                if (slot0_rise) begin
                    next_state = addressed ? SEL_ACTIVE : SEL_IDLE;
                end
            end
            SEL_ACTIVE: begin
                if (slot0_fall) begin
                    next_state = SEL_ADDRESSING;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state <= SEL_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------------
    // Module select line
    // ------------------------------------------------------------------
    // Low slot-zero select drops every module select at once.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            module_select <= 1'b0;
        end else if (slot0_fall) begin
            module_select <= 1'b0;
        end else if (state == SEL_ADDRESSING && slot0_rise) begin
            module_select <= addressed;
        end
    end

    // Holding the link side in reset while unselected reloads the
    // identification register and keeps serial clocks from acting.
    assign lif.link_rst_n = module_select;

    // ------------------------------------------------------------------
    // Last captured slot-select word
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            slot_select_word <= SEL_RESET;
        end else if (state == SEL_ADDRESSING && slot0_rise) begin
            slot_select_word <= sel_shift;
        end
    end

    // ------------------------------------------------------------------
    // Configuration register
    // ------------------------------------------------------------------
    // The staged word is frozen once slot-zero select is low, and the
    // link reset takes effect only after this capture edge.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            config_word <= CFG_RESET;
        end else if (module_select && slot0_fall && lif.cfg_written) begin
            config_word <= lif.cfg_stage;
        end
    end

    // ------------------------------------------------------------------
    // Link-side module port
    // ------------------------------------------------------------------
    mssp_id_port u_id_port (
        .serial_shift_clock (serial_shift_clock),
        .slot_zero_select_n (slot_zero_select_n),
        .data_address_flag  (data_address_flag),
        .serial_input_line  (serial_input_line),
        .lif                (lif)
    );

    // Output flop lives in the link-side port, on the falling edge.
    assign serial_output_line = lif.id_bit;

    // ------------------------------------------------------------------
    // Scan timing
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            backplane_trigger_line <= 1'b0;
        end else begin
            backplane_trigger_line <= scan_level;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            channel_mux_counter <= MUX_RESET;
        end else if (scan_rise) begin
            if (channel_mux_counter == MUX_LAST) begin
                channel_mux_counter <= MUX_RESET;
            end else begin
                channel_mux_counter <= channel_mux_counter + 3'h1;
            end
        end
    end

endmodule

// ### sim/mssp_top_props.sv
// Concurrent checks on the module serial select port pins
`timescale 1ns/1ps
module mssp_top_props
    import mssp_pkg::*;
(
    // Clock, reset and link
    input  wire logic                 clk,
    input  wire logic                 nrst,
    input  wire logic                 serial_shift_clock,
    input  wire logic                 serial_input_line,
    input  wire logic                 data_address_flag,
    input  wire logic                 slot_zero_select_n,
    input  wire logic                 serial_output_line,
    // Scan and straps
    input  wire logic                 scan_advance_clock,
    input  wire logic                 backplane_trigger_line,
    input  wire logic [MUX_W-1:0]     channel_mux_counter,
    input  wire logic [SLOT_W-1:0]    slot_position,
    input  wire logic [CHASSIS_W-1:0] chassis_address,
    input  wire logic                 single_chassis_mode,
    // Module state
    input  wire logic                 module_select,
    input  wire logic [CFG_W-1:0]     config_word,
    input  wire logic [SEL_W-1:0]     slot_select_word
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    a_mux_step: assert property ($changed(channel_mux_counter) |-> channel_mux_counter ==
        (($past(channel_mux_counter) == MUX_LAST) ? MUX_RESET : $past(channel_mux_counter) + 3'h1))
        else $error("mux counter stepped wrongly");
    a_mux_cause: assert property ($rose(scan_advance_clock) |-> ##[1:4] $changed(channel_mux_counter))
        else $error("scan edge did not advance mux counter");
    a_trig_lag: assert property ($rose(backplane_trigger_line) |-> $past(scan_advance_clock, 2))
        else $error("trigger rose without scan clock");
    a_sel_drop: assert property ($fell(slot_zero_select_n) |-> ##[1:4] !module_select)
        else $error("module select not dropped");
    a_sel_after: assert property ($rose(module_select) |-> slot_zero_select_n)
        else $error("module select rose while slot zero selected");
    a_sel_match: assert property ($rose(module_select) |-> slot_select_word[3:0] == slot_position
        && (single_chassis_mode || chassis_address == CHASSIS_ANY
        || slot_select_word[15:8] == chassis_address))
        else $error("module selected by foreign word");
    a_word_end: assert property ($changed(slot_select_word) |-> slot_zero_select_n)
        else $error("slot word changed mid transfer");
    a_cfg_end: assert property ($changed(config_word) |-> !slot_zero_select_n)
        else $error("config changed outside transfer end");
    a_out_quiet: assert property (!module_select [*4] |-> !serial_output_line)
        else $error("serial output active while unselected");

    c_select: cover property ($rose(module_select));
    c_config: cover property ($changed(config_word));
    c_wrap: cover property ($changed(channel_mux_counter) && channel_mux_counter == MUX_RESET);
endmodule

bind mssp_top mssp_top_props u_props (.clk(clk), .nrst(nrst),
    .serial_shift_clock(serial_shift_clock), .serial_input_line(serial_input_line),
    .data_address_flag(data_address_flag), .slot_zero_select_n(slot_zero_select_n),
    .serial_output_line(serial_output_line), .scan_advance_clock(scan_advance_clock),
    .backplane_trigger_line(backplane_trigger_line), .channel_mux_counter(channel_mux_counter),
    .slot_position(slot_position), .chassis_address(chassis_address),
    .single_chassis_mode(single_chassis_mode), .module_select(module_select),
    .config_word(config_word), .slot_select_word(slot_select_word));

// ### sim/mssp_host_model.sv
// Acquisition board model driving the serial link
`timescale 1ns/1ps
module mssp_host_model (
    // Link lines
    output logic      serial_shift_clock,
    output logic      serial_input_line,
    output logic      data_address_flag,
    output logic      slot_zero_select_n,
    input  wire logic serial_output_line
);
    localparam int HALF = 80;
    logic [63:0] rd_word;
    event        rd_done;

    initial begin
        serial_shift_clock = 1'b1;
        serial_input_line = 1'b0;
        data_address_flag = 1'b1;
        slot_zero_select_n = 1'b1;
    end

    // Clock stands high between frames; data line inverts once released
    task automatic shift(input int n, input logic [63:0] v, output logic [63:0] r);
        r = '0;
        for (int i = n - 1; i >= 0; i--) begin
            serial_input_line = v[i];
            #(HALF / 2);
            serial_shift_clock = 1'b0;
            #HALF;
            serial_shift_clock = 1'b1;
            #(HALF / 2);
            r = {r[62:0], serial_output_line};
        end
        serial_input_line = ~serial_input_line;
    endtask

    task automatic select(input logic [15:0] word);
        logic [63:0] r;
        slot_zero_select_n = 1'b0;
        #600;
        shift(16, {48'h0, word}, r);
        #600;
        slot_zero_select_n = 1'b1;
        #600;
    endtask

    task automatic transfer(input logic flag, input int n, input logic [63:0] v);
        data_address_flag = flag;
        shift(n, v, rd_word);
        if (flag)
            -> rd_done;
        #600;
        slot_zero_select_n = 1'b0;
        #600;
    endtask
endmodule

// ### sim/tb_mssp_top.sv
// Self-checking bench for the module serial select port
`timescale 1ns/1ps
module tb_mssp_top;
    import mssp_pkg::*;
    logic                 clk, nrst, sclk, din, flag, sel_n, dout, scan, trig, single, msel, ms_d;
    logic [MUX_W-1:0]     mux, mux_d, mux_exp;
    logic [SLOT_W-1:0]    slot;
    logic [CHASSIS_W-1:0] chas;
    logic [CFG_W-1:0]     cfg, cfg_d, rnd;
    logic [SEL_W-1:0]     sword, word;
    logic [63:0]          q_sel[$], q_cfg[$], q_mux[$], q_id[$];
    int                   num_errors = 0, n_compared = 0, seed = 28511;

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    mssp_top uut (.clk(clk), .nrst(nrst), .serial_shift_clock(sclk), .serial_input_line(din),
        .data_address_flag(flag), .slot_zero_select_n(sel_n), .serial_output_line(dout),
        .scan_advance_clock(scan), .backplane_trigger_line(trig), .channel_mux_counter(mux),
        .slot_position(slot), .chassis_address(chas), .single_chassis_mode(single),
        .module_select(msel), .config_word(cfg), .slot_select_word(sword));
    mssp_host_model host (.serial_shift_clock(sclk), .serial_input_line(din),
        .data_address_flag(flag), .slot_zero_select_n(sel_n), .serial_output_line(dout));

    task automatic chk(input logic [63:0] e, input logic [63:0] g);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED at %0t: expected %h got %h", $time, e, g);
        end
    endtask

    task automatic take(ref logic [63:0] q[$], input logic [63:0] g);
        if (q.size() == 0)
            chk('x, g);
        else
            chk(q.pop_front(), g);
    endtask

    task automatic end_of_test();
        chk(64'h0, 64'(q_sel.size() + q_cfg.size() + q_mux.size() + q_id.size()));
        if (num_errors == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // --------------------------------------------------------------
    // Result watchers
    // --------------------------------------------------------------
    always @(negedge clk) begin
        if (nrst) begin
            if (msel && !ms_d) take(q_sel, 64'(sword));
            if (cfg !== cfg_d) take(q_cfg, 64'(cfg));
            if (mux !== mux_d) take(q_mux, 64'(mux));
        end
        ms_d = msel;
        cfg_d = cfg;
        mux_d = mux;
    end

    initial forever begin
        @(host.rd_done);
        take(q_id, host.rd_word);
    end

    initial begin
        #1000000;
        num_errors++;
        end_of_test();
    end

    // --------------------------------------------------------------
    // Stimulus
    // --------------------------------------------------------------
    initial begin
        nrst = 1'b0;
        scan = 1'b0;
        single = 1'b0;
        slot = 4'h0;
        chas = 8'h00;
        mux_exp = MUX_RESET;
        repeat (12) @(negedge clk);
        nrst = 1'b1;
        slot = 4'($random(seed));
        if (slot == 4'h0) slot = 4'h5;
        chas = 8'($random(seed));
        if (chas == 8'h00) chas = 8'h3c;
        repeat (4) @(negedge clk);
        chk(64'h0, 64'({msel, cfg, sword, mux, dout}));
        for (int i = 0; i < 7; i++) begin
            mux_exp = (mux_exp == MUX_LAST) ? MUX_RESET : mux_exp + 3'h1;
            q_mux.push_back(64'(mux_exp));
            scan = 1'b1;
            repeat (4) @(negedge clk);
            chk(64'h1, 64'(trig));
            scan = 1'b0;
            repeat (4) @(negedge clk);
            chk(64'h0, 64'(trig));
        end
        word = {chas, 4'($random(seed)), slot};
        q_sel.push_back(64'(word));
        host.select(word);
        q_cfg.push_back(64'h830f);
        host.transfer(1'b0, 16, 64'h830f);
        host.select({~chas, 4'h0, slot});
        host.transfer(1'b0, 16, 64'h1234);
        @(negedge clk);
        chas = 8'h00;
        repeat (4) @(negedge clk);
        word = {8'($random(seed)), 4'h0, slot};
        q_sel.push_back(64'(word));
        host.select(word);
        q_id.push_back(64'({ID_VALUE, 8'h00}));
        host.transfer(1'b1, 40, 64'($random(seed)));
        q_sel.push_back(64'(word));
        host.select(word);
        q_id.push_back(64'(ID_VALUE));
        host.transfer(1'b1, 32, 64'h0);
        @(negedge clk);
        chas = 8'h77;
        single = 1'b1;
        repeat (4) @(negedge clk);
        q_sel.push_back(64'({8'h12, 4'h0, slot}));
        host.select({8'h12, 4'h0, slot});
        rnd = 16'($random(seed));
        if (rnd == 16'h830f) rnd = ~rnd;
        q_cfg.push_back(64'(rnd));
        host.transfer(1'b0, 16, 64'(rnd));
        host.select(16'h0000);
        repeat (10) @(negedge clk);
        end_of_test();
    end
endmodule
